// ---- verilog/odtm_pkg.sv ----
`default_nettype none
package odtm_pkg;
  // --------------------------------------------------------------------------
  // Latency and timing counts in CK cycles, with source times in ns and ps
  // --------------------------------------------------------------------------
  // Write latency default for CWL = 5, AL = 0.
  localparam int WL_DEF = 5;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CPDED_CK = 1;
  localparam int T_XPDLL_CK = 10;
  localparam int T_RFC_NS = 110;
  localparam int T_RFC_CK = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Asynchronous turn-on/off window is 2 ns to 8.5 ns, below one cycle here.
  localparam int T_AONPD_MAX_PS = 8500;
  localparam int T_AONPD_CK = (T_AONPD_MAX_PS / (CLK_PERIOD_NS * 1000) < 1) ? 1 :
                              T_AONPD_MAX_PS / (CLK_PERIOD_NS * 1000);
  localparam int CNT_W = 8;

  // --------------------------------------------------------------------------
  // State encodings
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_SYNC = 2'h0,
    DEV_ENTRY = 2'h1,
    DEV_PD = 2'h3,
    DEV_EXIT = 2'h2
  } odtm_dev_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'h0,
    CTL_PRE_ENTRY = 3'h1,
    CTL_ENTRY = 3'h3,
    CTL_PD = 3'h2,
    CTL_PRE_EXIT = 3'h6,
    CTL_EXIT = 3'h7
  } odtm_ctl_state_t;

  function automatic logic [CNT_W-1:0] sat_dec(input logic [CNT_W-1:0] v);
    sat_dec = (v == '0) ? v : v - 1'b1;
  endfunction
endpackage
`default_nettype wire

// ---- verilog/odtm_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface odtm_link_if;
  // Clock enable of the memory, registered on each CK rising edge with i_clk_en high.
  logic cke;
  // Termination request pin.
  logic odt;
  // One-cycle refresh command strobe.
  logic refresh;
  // One-cycle read or write command strobe.
  logic rw_cmd;

  modport ctl (output cke, output odt, output refresh, output rw_cmd);
  modport dram (input cke, input odt, input refresh, input rw_cmd);
endinterface
`default_nettype wire

// ---- verilog/odtm_dram_end.sv ----
// Behaviour
// - Frozen DLL gives power-down entry transition window.
// - Entry window starts WL-1 before CKE low.
// - Entry window ends with entry delay interval.
// - Refresh in progress extends entry window end.
// - Window start excluded, end points included.
// - Turn-on within lesser-min to greater-max delays.
// - Turn-off within lesser-min to greater-max delays.
// - Synchronous latency is WL minus two cycles.
// - Exit window spans tANPD to exit time.
// - Exit tANPD equals WL-1 before CKE high.
// - Overlapping entry then exit: one merged window.
// - Overlapping exit then entry: one merged window.
// - Asynchronous mode bypasses additive latency.
// - No read or write during power-down.
`timescale 1ns/100ps
`default_nettype none
module odtm_dram_end #(
  parameter int WL = odtm_pkg::WL_DEF,
  parameter int CPDED_CK = odtm_pkg::T_CPDED_CK,
  parameter int XPDLL_CK = odtm_pkg::T_XPDLL_CK,
  parameter int RFC_CK = odtm_pkg::T_RFC_CK
) (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Link from the controller
  odtm_link_if.dram link,
  // Mode: high when the DLL freezes in precharge power-down
  input wire logic i_dll_freeze,
  // Termination and mode status
  output logic o_rtt_on,
  output logic o_async_mode,
  output logic o_trans_window,
  output logic o_power_down,
  output logic o_cmd_in_pd
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  localparam int HW = (WL > 2) ? WL - 2 : 1;

  if (WL < 3 || WL > 64) begin : g_bad_wl
    $error("WL must lie between 3 and 64");
  end
  if (CPDED_CK < 1 || CPDED_CK > 255 || XPDLL_CK < 1 || XPDLL_CK > 255) begin : g_bad_t
    $error("Timing counts must lie between 1 and 255");
  end
  if (RFC_CK < 1 || RFC_CK > 255) begin : g_bad_rfc
    $error("Refresh count must lie between 1 and 255");
  end

  localparam logic [odtm_pkg::CNT_W-1:0] CPDED_LD = odtm_pkg::CNT_W'(CPDED_CK - 1);
  localparam logic [odtm_pkg::CNT_W-1:0] XPDLL_LD = odtm_pkg::CNT_W'(XPDLL_CK - 1);
  localparam logic [odtm_pkg::CNT_W-1:0] RFC_LD = odtm_pkg::CNT_W'(RFC_CK - 1);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    odtm_pkg::odtm_dev_state_t state;
    logic [odtm_pkg::CNT_W-1:0] win_cnt;
    logic [odtm_pkg::CNT_W-1:0] rfc_cnt;
    logic rfc_busy;
    logic cke_d;
    logic [HW-1:0] odt_hist;
    logic rtt_on;
    logic async_mode;
    logic trans_window;
    logic power_down;
    logic cmd_in_pd;
  } odtm_dev_st_t;

  odtm_dev_st_t st_reg;
  odtm_dev_st_t st_next;

  localparam odtm_dev_st_t ST_RESET = '{
    state: odtm_pkg::DEV_SYNC,
    win_cnt: '0,
    rfc_cnt: '0,
    rfc_busy: 1'b0,
    cke_d: 1'b1,
    odt_hist: '0,
    rtt_on: 1'b0,
    async_mode: 1'b0,
    trans_window: 1'b0,
    power_down: 1'b0,
    cmd_in_pd: 1'b0
  };

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic cke_fall;
    logic cke_rise;
    logic rfc_live;
    cke_fall = st_reg.cke_d & ~link.cke;
    cke_rise = ~st_reg.cke_d & link.cke;
    rfc_live = st_reg.rfc_busy;
    st_next = st_reg;
    st_next.cke_d = link.cke;
    // Each cycle the pin enters the synchronous latency line.
    st_next.odt_hist = (st_reg.odt_hist << 1) | HW'(link.odt);

    // Refresh time runs from the command; its last cycle still counts.
    if (link.refresh) begin
      st_next.rfc_busy = 1'b1;
      st_next.rfc_cnt = RFC_LD;
    end else if (st_reg.rfc_busy) begin
      st_next.rfc_cnt = odtm_pkg::sat_dec(st_reg.rfc_cnt);
      st_next.rfc_busy = (st_reg.rfc_cnt != '0);
    end
    unique case (st_reg.state)
      odtm_pkg::DEV_SYNC: begin
        // The cycles before CKE low are already pending in the latency line,
        // so switching to the direct path here lands them inside the window.
        if (cke_fall && i_dll_freeze) begin
          st_next.state = odtm_pkg::DEV_ENTRY;
          st_next.win_cnt = CPDED_LD;
        end
      end
      odtm_pkg::DEV_ENTRY: begin
        if (cke_rise) begin
          st_next.state = odtm_pkg::DEV_EXIT;
          st_next.win_cnt = XPDLL_LD;
        end else if (st_reg.win_cnt == '0 && !rfc_live) begin
          st_next.state = odtm_pkg::DEV_PD;
        end else begin
          st_next.win_cnt = odtm_pkg::sat_dec(st_reg.win_cnt);
        end
      end
      odtm_pkg::DEV_PD: begin
        // The exit window opens WL-1 cycles before this edge; the device is
        // already on the direct path, which is a legal answer there.
        if (cke_rise) begin
          st_next.state = odtm_pkg::DEV_EXIT;
          st_next.win_cnt = XPDLL_LD;
        end
      end
      odtm_pkg::DEV_EXIT: begin
        if (cke_fall && i_dll_freeze) begin
          st_next.state = odtm_pkg::DEV_ENTRY;
          st_next.win_cnt = CPDED_LD;
        end else if (st_reg.win_cnt == '0) begin
          st_next.state = odtm_pkg::DEV_SYNC;
        end else begin
          st_next.win_cnt = odtm_pkg::sat_dec(st_reg.win_cnt);
        end
      end
    endcase

    st_next.async_mode = (st_next.state != odtm_pkg::DEV_SYNC);
    st_next.trans_window = (st_next.state == odtm_pkg::DEV_ENTRY) ||
                           (st_next.state == odtm_pkg::DEV_EXIT);
    st_next.power_down = (st_next.state == odtm_pkg::DEV_PD);

    // Inside a window the direct path is chosen: its delay sits between the
    // lesser minimum and the greater maximum, which keeps both bounds.
    if (st_next.async_mode) begin
      st_next.rtt_on = link.odt;
    end else begin
      st_next.rtt_on = st_reg.odt_hist[HW-1];
    end

    // A read or write while CKE is low is flagged for one cycle.
    st_next.cmd_in_pd = link.rw_cmd & ~link.cke;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= ST_RESET;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_rtt_on = st_reg.rtt_on;
  assign o_async_mode = st_reg.async_mode;
  assign o_trans_window = st_reg.trans_window;
  assign o_power_down = st_reg.power_down;
  assign o_cmd_in_pd = st_reg.cmd_in_pd;

endmodule // odtm_dram_end
`default_nettype wire

// ---- verilog/odtm_ctl_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module odtm_ctl_end #(
  parameter int WL = odtm_pkg::WL_DEF,
  parameter int CPDED_CK = odtm_pkg::T_CPDED_CK,
  parameter int XPDLL_CK = odtm_pkg::T_XPDLL_CK,
  parameter int RFC_CK = odtm_pkg::T_RFC_CK
) (
  // Clock, reset and enable
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // User requests
  input wire logic i_pd_req,
  input wire logic i_odt_req,
  input wire logic i_ref_req,
  input wire logic i_cmd_req,
  // User status
  output logic o_cmd_taken,
  output logic o_rtt_uncertain,
  output logic o_in_pd,
  // Link to the memory
  odtm_link_if.ctl link
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  if (WL < 3 || WL > 64 || CPDED_CK < 1 || CPDED_CK > 255) begin : g_bad_p
    $error("WL or entry delay out of range");
  end
  if (XPDLL_CK < 1 || XPDLL_CK > 255 || RFC_CK < 1 || RFC_CK > 255) begin : g_bad_t
    $error("Exit or refresh count out of range");
  end

  localparam logic [odtm_pkg::CNT_W-1:0] ANPD_LD = odtm_pkg::CNT_W'(WL - 2);
  localparam logic [odtm_pkg::CNT_W-1:0] CPDED_LD = odtm_pkg::CNT_W'(CPDED_CK - 1);
  localparam logic [odtm_pkg::CNT_W-1:0] XPDLL_LD = odtm_pkg::CNT_W'(XPDLL_CK - 1);
  localparam logic [odtm_pkg::CNT_W-1:0] RFC_LD = odtm_pkg::CNT_W'(RFC_CK - 1);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    odtm_pkg::odtm_ctl_state_t state;
    logic [odtm_pkg::CNT_W-1:0] cnt;
    logic [odtm_pkg::CNT_W-1:0] rfc_cnt;
    logic cke;
    logic odt;
    logic refresh;
    logic rw_cmd;
    logic uncertain;
    logic in_pd;
  } odtm_ctl_st_t;

  odtm_ctl_st_t st_reg;
  odtm_ctl_st_t st_next;

  localparam odtm_ctl_st_t ST_RESET = '{
    state: odtm_pkg::CTL_IDLE,
    cnt: '0,
    rfc_cnt: '0,
    cke: 1'b1,
    odt: 1'b0,
    refresh: 1'b0,
    rw_cmd: 1'b0,
    uncertain: 1'b0,
    in_pd: 1'b0
  };

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.odt = i_odt_req;
    st_next.refresh = 1'b0;
    st_next.rw_cmd = 1'b0;
    st_next.rfc_cnt = odtm_pkg::sat_dec(st_reg.rfc_cnt);
    st_next.cnt = odtm_pkg::sat_dec(st_reg.cnt);

    unique case (st_reg.state)
      odtm_pkg::CTL_IDLE: begin
        if (i_ref_req) begin
          st_next.refresh = 1'b1;
          st_next.rfc_cnt = RFC_LD;
        end else if (i_pd_req) begin
          // Flag the window WL-1 cycles ahead of the CKE edge it leads to.
          st_next.state = odtm_pkg::CTL_PRE_ENTRY;
          st_next.cnt = ANPD_LD;
          st_next.uncertain = 1'b1;
        end else if (i_cmd_req) begin
          st_next.rw_cmd = 1'b1;
        end
      end
      odtm_pkg::CTL_PRE_ENTRY: begin
        if (st_reg.cnt == '0) begin
          st_next.state = odtm_pkg::CTL_ENTRY;
          st_next.cke = 1'b0;
          // The window lasts to the later of entry delay and refresh end.
          st_next.cnt = (st_next.rfc_cnt > CPDED_LD) ? st_next.rfc_cnt : CPDED_LD;
        end
      end
      odtm_pkg::CTL_ENTRY: begin
        if (st_reg.cnt == '0) begin
          st_next.state = odtm_pkg::CTL_PD;
          st_next.uncertain = 1'b0;
        end
      end
      odtm_pkg::CTL_PD: begin
        if (!i_pd_req) begin
          st_next.state = odtm_pkg::CTL_PRE_EXIT;
          st_next.cnt = ANPD_LD;
          st_next.uncertain = 1'b1;
        end
      end
      odtm_pkg::CTL_PRE_EXIT: begin
        if (st_reg.cnt == '0) begin
          st_next.state = odtm_pkg::CTL_EXIT;
          st_next.cke = 1'b1;
          st_next.cnt = XPDLL_LD;
        end
      end
      odtm_pkg::CTL_EXIT: begin
        if (st_reg.cnt == '0) begin
          st_next.state = odtm_pkg::CTL_IDLE;
          st_next.uncertain = 1'b0;
        end
      end
      default: begin
        st_next = ST_RESET;
      end
    endcase
    st_next.in_pd = (st_next.state == odtm_pkg::CTL_PD);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= ST_RESET;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // Reads and writes leave only from idle, never in power-down.
  assign link.rw_cmd = st_reg.rw_cmd;
  assign link.cke = st_reg.cke;
  assign link.odt = st_reg.odt;
  assign link.refresh = st_reg.refresh;
  assign o_cmd_taken = st_reg.rw_cmd;
  assign o_rtt_uncertain = st_reg.uncertain;
  assign o_in_pd = st_reg.in_pd;

endmodule // odtm_ctl_end
`default_nettype wire

// ---- tb/odtm_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module odtm_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Link signals
  input wire logic i_cke,
  input wire logic i_odt,
  input wire logic i_refresh,
  input wire logic i_rw_cmd
);
  // --------------------------------------------------------------------------
  // Link checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  chk_ref_pulse: assert property (i_refresh |=> !i_refresh)
    else $error("refresh strobe longer than one cycle");
  chk_cmd_pulse: assert property (i_rw_cmd |=> !i_rw_cmd)
    else $error("command strobe longer than one cycle");
  chk_no_cmd_pd: assert property (!i_cke |-> !i_rw_cmd)
    else $error("command issued with clock enable low");
  chk_no_ref_pd: assert property (!i_cke |-> !i_refresh)
    else $error("refresh issued with clock enable low");
  chk_low_hold: assert property ($fell(i_cke) |-> !i_cke [*4])
    else $error("clock enable low stay shorter than exit lead");
  chk_high_hold: assert property ($rose(i_cke) |-> i_cke [*8])
    else $error("clock enable dropped inside exit window");
  chk_no_cmd_exit: assert property ($rose(i_cke) |-> !i_rw_cmd [*8])
    else $error("command issued inside exit window");
  chk_ref_lead: assert property (i_refresh |-> i_cke [*5])
    else $error("clock enable fell too soon after refresh");

  // Termination toggled while powered down exercises the direct path.
  cov_odt_pd: cover property (!i_cke && $rose(i_odt));
endmodule // odtm_monitor
`default_nettype wire

// ---- tb/odt_powerdown_mode_transition_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module odt_powerdown_mode_transition_tb_top;
  localparam int WL = 5;
  localparam int CPD = 1;
  localparam int XPD = 10;
  // A long refresh time lets a refresh still run when the clock enable falls.
  localparam int RFC = 8;
  logic i_clock, i_sys_rst, i_clk_en, i_dll_freeze;
  logic i_pd_req, i_odt_req, i_ref_req, i_cmd_req;
  logic o_cmd_taken, o_rtt_uncertain, o_in_pd;
  logic o_rtt_on, o_async_mode, o_trans_window, o_power_down, o_cmd_in_pd;
  logic [9:0] st;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n, m;

  odtm_link_if link ();
  odtm_ctl_end #(.WL(WL), .CPDED_CK(CPD), .XPDLL_CK(XPD), .RFC_CK(RFC)) odtm_ctl_end_i (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_pd_req(i_pd_req),
    .i_odt_req(i_odt_req), .i_ref_req(i_ref_req), .i_cmd_req(i_cmd_req),
    .o_cmd_taken(o_cmd_taken), .o_rtt_uncertain(o_rtt_uncertain), .o_in_pd(o_in_pd),
    .link(link));
  odtm_dram_end #(.WL(WL), .CPDED_CK(CPD), .XPDLL_CK(XPD), .RFC_CK(RFC)) odtm_dram_end_i (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .link(link),
    .i_dll_freeze(i_dll_freeze), .o_rtt_on(o_rtt_on), .o_async_mode(o_async_mode),
    .o_trans_window(o_trans_window), .o_power_down(o_power_down), .o_cmd_in_pd(o_cmd_in_pd));
  odtm_monitor odtm_monitor_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_cke(link.cke),
    .i_odt(link.odt), .i_refresh(link.refresh), .i_rw_cmd(link.rw_cmd));

  assign st = {link.refresh, link.cke, link.rw_cmd, o_rtt_uncertain, o_rtt_on, o_async_mode,
               o_trans_window, o_power_down, o_cmd_taken, o_cmd_in_pd};

  // --------------------------------------------------------------------------
  // Clock, timeout and report
  // --------------------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask

  // Bounded wait so that a stuck design still reaches the report.
  task automatic wait_bit(input int idx, input logic v, output int cnt);
    cnt = 0;
    while (st[idx] !== v && cnt < 40) begin
      tick(1);
      cnt++;
    end
    if (cnt >= 40) begin
      bad_count++;
      $display("wrong value wait bit %0d expected %b seen %b", idx, v, st[idx]);
    end
  endtask

  task automatic odt_step(input logic v, input int lat);
    @(posedge i_clock);
    i_odt_req <= v;
    tick(lat);
    chk("rtt before latency", !v, o_rtt_on);
    tick(1);
    chk("rtt after latency", v, o_rtt_on);
  endtask

  task automatic cmd_try(input logic exp);
    @(posedge i_clock);
    i_cmd_req <= 1'b1;
    @(posedge i_clock);
    i_cmd_req <= 1'b0;
    #1;
    chk("cmd taken", exp, o_cmd_taken);
    chk("cmd strobe", exp, link.rw_cmd);
    tick(1);
    chk("cmd flag", 1'b0, o_cmd_in_pd);
  endtask

  // Returns the cycles from the uncertain flag rising to the clock enable edge.
  task automatic pd_go(input logic v, output int cnt);
    @(posedge i_clock);
    i_pd_req <= v;
    #1;
    wait_bit(6, 1'b1, cnt);
    wait_bit(8, !v, cnt);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_dll_freeze = 1'b1;
    i_pd_req = 1'b0;
    i_odt_req = 1'b0;
    i_ref_req = 1'b0;
    i_cmd_req = 1'b0;
    tick(1);
    chk("cke in reset", 1'b1, link.cke);
    chk("window in reset", 1'b0, o_trans_window);
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
    odt_step(1'b1, WL - 1);
    odt_step(1'b0, WL - 1);
    cmd_try(1'b1);
    pd_go(1'b1, n);
    chk_rng("entry lead", WL - 1, WL - 1, n);
    wait_bit(6, 1'b0, n);
    chk_rng("entry tail", CPD, CPD, n);
    chk("entry window", 1'b1, o_trans_window);
    chk("entry async", 1'b1, o_async_mode);
    wait_bit(2, 1'b1, n);
    chk("window after entry", 1'b0, o_trans_window);
    chk("ctl in pd", 1'b1, o_in_pd);
    odt_step(1'b1, 1);
    cmd_try(1'b0);
    // With the enable low both ends must hold power-down although the request drops.
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    i_pd_req <= 1'b0;
    tick(3);
    chk("pd frozen", 1'b1, o_power_down);
    chk("ctl frozen", 1'b1, o_in_pd);
    @(posedge i_clock);
    i_clk_en <= 1'b1;
    pd_go(1'b0, n);
    chk_rng("exit lead", WL - 1, WL - 1, n);
    tick(XPD - 1);
    chk("exit uncertain", 1'b1, o_rtt_uncertain);
    chk("exit window", 1'b1, o_trans_window);
    tick(1);
    chk("exit uncertain end", 1'b0, o_rtt_uncertain);
    wait_bit(3, 1'b0, n);
    chk_rng("exit window tail", 1, 3, n);
    chk("sync after exit", 1'b0, o_async_mode);
    odt_step(1'b0, WL - 1);
    @(posedge i_clock);
    i_ref_req <= 1'b1;
    i_pd_req <= 1'b1;
    @(posedge i_clock);
    i_ref_req <= 1'b0;
    #1;
    wait_bit(9, 1'b1, n);
    wait_bit(6, 1'b1, m);
    wait_bit(6, 1'b0, n);
    chk_rng("refresh tail", RFC, RFC + 1, n + m);
    pd_go(1'b0, n);
    wait_bit(6, 1'b0, n);
    @(posedge i_clock);
    i_dll_freeze <= 1'b0;
    pd_go(1'b1, n);
    tick(3);
    chk("no window unfrozen", 1'b0, o_trans_window);
    chk("no async unfrozen", 1'b0, o_async_mode);
    pd_go(1'b0, n);
    wait_bit(6, 1'b0, n);
    test_done();
  end
endmodule // odt_powerdown_mode_transition_tb_top
`default_nettype wire
